// ===== core/hsp_map.vh
`ifndef HSP_MAP_VH
`define HSP_MAP_VH
`define HSP_OFF_STRUCT       8'h04
`define HSP_BIT_PORT_IND     16
`define HSP_CC_MSB           15
`define HSP_CC_LSB           12
`define HSP_PCC_MSB          11
`define HSP_PCC_LSB          8
`define HSP_BIT_ROUTE        7
`define HSP_BIT_PWR          4
`define HSP_PORTS_MSB        3
`define HSP_PORTS_LSB        0
`define HSP_RST_CC           4'h2
`define HSP_RST_PCC          4'h2
`define HSP_RST_ROUTE        1'h1
`define HSP_RST_PWR          1'h1
`define HSP_RST_PORTS        4'h4
`define HSP_OFF_PORT0        8'h44
`define HSP_PORT_STRIDE      8'h04
`define HSP_PORT_IND_MSB     15
`define HSP_PORT_IND_LSB     14
`define HSP_PORT_PWR         12
`endif

// ===== core/hsp_port_ctl.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Per-port indicator and power control fields.
// ----------------------------------------------------------------
module hsp_port_ctl #(
	parameter N_PORTS = 4
) (
	input  wire                 i_clk,
	input  wire                 i_rstn,
	input  wire                 i_ind_cap,
	input  wire                 i_pwr_cap,
	input  wire [N_PORTS-1:0]   i_wr_en,
	input  wire [1:0]           i_wr_ind,
	input  wire                 i_wr_pwr,
	output wire [2*N_PORTS-1:0] o_ind,
	output wire [N_PORTS-1:0]   o_pwr
);
	genvar g;
	generate
		for (g = 0; g < N_PORTS; g = g + 1) begin : port
			reg [1:0] ind_reg;
			reg       pwr_reg;
			always @(posedge i_clk) begin
				if (!i_rstn) begin
					ind_reg <= 2'h0;
					pwr_reg <= 1'h0;
				end else if (i_wr_en[g]) begin
					// Indicator field exists only when capable.
					ind_reg <= i_ind_cap ? i_wr_ind : 2'h0;
					pwr_reg <= i_wr_pwr;
				end
			end
			assign o_ind[2*g+1:2*g] = ind_reg;
			// Without switches the ports are always powered.
			assign o_pwr[g] = i_pwr_cap ? pwr_reg : 1'h1;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== core/hsp_struct_params.v
// How it works
// - Port indicator bit 16 loads from amber strap three during reset.
// - Indicator capable means each port gets a writable indicator field.
// - Companion count in bits 15..12; zero means high-speed only.
// - Nonzero companion count enables port ownership hand-off.
// - Ports per companion in bits 11..8 reports routing group size.
// - Ports per companion times companions must cover all ports.
// - Routing bit 7 zero maps consecutive port groups to companions.
// - Routing bit one takes companion per port from route array.
// - Bit 4 reads one when ports have power switches.
// - Port power field behaviour follows the power switch bit.
// - Bits 3..0 give port count; that many port registers exist.
// - Port count is always 1h to Fh, never zero.
// - Register sits at offset 04h and is read only.
`timescale 1ns/1ps
`default_nettype none
`include "hsp_map.vh"
module hsp_struct_params #(
	parameter [3:0] N_PORTS  = `HSP_RST_PORTS,
	parameter [3:0] N_CC     = `HSP_RST_CC,
	parameter [3:0] PORTS_PER_COMPANION    = `HSP_RST_PCC,
	parameter       ROUTE    = `HSP_RST_ROUTE,
	parameter       PWR_CAP  = `HSP_RST_PWR,
	parameter [4*15-1:0] ROUTE_ARRAY = 60'h0
) (
	input  wire                 i_clk,
	input  wire                 i_rstn,
	input  wire                 i_amber_led_strap_three,
	input  wire [7:0]           i_addr,
	input  wire                 i_rd,
	input  wire                 i_wr,
	input  wire [31:0]          i_wdata,
	input  wire [3:0]           i_port_sel,
	output reg  [31:0]          o_rdata,
	output wire                 o_handoff_enable,
	output reg  [3:0]           o_port_companion,
	output wire [14:0]          o_port_reg_valid,
	output wire [2*N_PORTS-1:0] o_port_ind,
	output wire [N_PORTS-1:0]   o_port_pwr
);
	// ----------------------------------------------------------------
	// Strap capture.
	// ----------------------------------------------------------------
	reg  strap_s1_reg;
	reg  strap_s2_reg;
	reg  ind_cap_reg;
	always @(posedge i_clk) begin
		strap_s1_reg <= i_amber_led_strap_three;
		strap_s2_reg <= strap_s1_reg;
		if (!i_rstn)
			ind_cap_reg <= strap_s2_reg;
	end

	// ----------------------------------------------------------------
	// Decode helpers.
	// ----------------------------------------------------------------
	// Matches the byte offset of the port register of port n.
	function port_hit;
		input [7:0] addr;
		input integer n;
		begin
			port_hit = (addr == `HSP_OFF_PORT0 + `HSP_PORT_STRIDE * n);
		end
	endfunction

	// Counts the full companion groups that lie below a port.
	function [3:0] group_of;
		input [3:0] sel;
		input [3:0] pcc;
		integer     k;
		begin
			group_of = 4'h0;
			for (k = 1; k < 16; k = k + 1) begin
				if (k[3:0] <= sel && pcc != 4'h0 && k[3:0] % pcc == 4'h0)
					group_of = group_of + 4'h1;
			end
		end
	endfunction

	// Keeps a group index inside the companions that exist.
	function [3:0] clamp_group;
		input [3:0] grp;
		input [3:0] cc;
		begin
			if (grp < cc)
				clamp_group = grp;
			else
				clamp_group = cc - 4'h1;
		end
	endfunction

	// Picks the explicit companion entry of a port.
	function [3:0] route_entry;
		input [3:0] sel;
		begin
			route_entry = ROUTE_ARRAY[4*sel +: 4];
		end
	endfunction

	function [31:0] port_word;
		input [1:0] ind;
		input       pwr;
		begin
			port_word = 32'h0;
			port_word[`HSP_PORT_IND_MSB:`HSP_PORT_IND_LSB] = ind;
			port_word[`HSP_PORT_PWR] = pwr;
		end
	endfunction

	// ----------------------------------------------------------------
	// Derived values.
	// ----------------------------------------------------------------
	wire [3:0] ports_eff;
	wire [3:0] pcc_eff;
	wire       has_cc;
	wire       pcc_zero;
	assign ports_eff = (N_PORTS == 4'h0) ? 4'h1 : N_PORTS;
	assign has_cc = (N_CC != 4'h0);
	assign pcc_zero = (PORTS_PER_COMPANION == 4'h0);
	assign pcc_eff = (has_cc && pcc_zero) ? ports_eff : PORTS_PER_COMPANION;
	assign o_handoff_enable = has_cc;

	// ----------------------------------------------------------------
	// Register value.
	// ----------------------------------------------------------------
	wire [31:0] struct_val;
	assign struct_val[31:17] = 15'h0;
	assign struct_val[`HSP_BIT_PORT_IND] = ind_cap_reg;
	assign struct_val[`HSP_CC_MSB:`HSP_CC_LSB] = N_CC;
	assign struct_val[`HSP_PCC_MSB:`HSP_PCC_LSB] = pcc_eff;
	assign struct_val[`HSP_BIT_ROUTE] = ROUTE[0];
	assign struct_val[6:5] = 2'h0;
	assign struct_val[`HSP_BIT_PWR] = PWR_CAP[0];
	assign struct_val[`HSP_PORTS_MSB:`HSP_PORTS_LSB] = ports_eff;

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------
	wire               struct_hit;
	wire [N_PORTS-1:0] port_sel_hit;
	wire [N_PORTS-1:0] port_wr;
	assign struct_hit = (i_addr == `HSP_OFF_STRUCT);
	genvar g;
	generate
		for (g = 0; g < N_PORTS; g = g + 1) begin : pw
			assign port_sel_hit[g] = port_hit(i_addr, g);
			assign port_wr[g] = i_wr && port_sel_hit[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data.
	// ----------------------------------------------------------------
	reg [31:0] port_rdata;
	integer    pn;
	always @* begin
		port_rdata = 32'h0;
		for (pn = 0; pn < N_PORTS; pn = pn + 1) begin
			if (port_sel_hit[pn])
				port_rdata = port_word(o_port_ind[2*pn+:2], o_port_pwr[pn]);
		end
	end

	always @(posedge i_clk) begin
		if (!i_rstn)
			o_rdata <= 32'h0;
		else if (i_rd && struct_hit)
			o_rdata <= struct_val;
		else if (i_rd && |port_sel_hit)
			o_rdata <= port_rdata;
		else if (i_rd)
			o_rdata <= 32'h0;
	end

	// ----------------------------------------------------------------
	// Port routing.
	// ----------------------------------------------------------------
	wire [3:0] sel_group;
	wire [3:0] sel_seq;
	wire       sel_out;
	assign sel_group = group_of(i_port_sel, pcc_eff);
	assign sel_seq = clamp_group(sel_group, N_CC);
	assign sel_out = (i_port_sel >= ports_eff);

	always @(posedge i_clk) begin
		if (!i_rstn)
			o_port_companion <= 4'h0;
		else if (!has_cc || sel_out)
			o_port_companion <= 4'h0;
		else if (ROUTE[0])
			o_port_companion <= route_entry(i_port_sel);
		else
			o_port_companion <= sel_seq;
	end

	// ----------------------------------------------------------------
	// Port register presence.
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < 15; g = g + 1) begin : pv
			assign o_port_reg_valid[g] = (g < ports_eff);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Port control fields.
	// ----------------------------------------------------------------
	hsp_port_ctl #(
		.N_PORTS (N_PORTS)
	) u_port (
		.i_clk     (i_clk),
		.i_rstn    (i_rstn),
		.i_ind_cap (ind_cap_reg),
		.i_pwr_cap (PWR_CAP[0]),
		.i_wr_en   (port_wr),
		.i_wr_ind  (i_wdata[`HSP_PORT_IND_MSB:`HSP_PORT_IND_LSB]),
		.i_wr_pwr  (i_wdata[`HSP_PORT_PWR]),
		.o_ind     (o_port_ind),
		.o_pwr     (o_port_pwr)
	);
endmodule
`default_nettype wire

// ===== verif/hsp_struct_params_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_struct_params_assertions #(
	parameter [3:0] N_PORTS = 4'h4
) (
	input wire logic                 i_clk,
	input wire logic                 i_rstn,
	input wire logic [7:0]           i_addr,
	input wire logic                 i_rd,
	input wire logic [31:0]          o_rdata,
	input wire logic                 o_handoff_enable,
	input wire logic [14:0]          o_port_reg_valid,
	input wire logic [2*N_PORTS-1:0] o_port_ind,
	input wire logic [N_PORTS-1:0]   o_port_pwr
);
	wire [7:0] w_cover = o_rdata[15:12] * o_rdata[11:8];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_rd;
		i_rd && i_addr == 8'h04;
	endsequence
	property p_hand;
		s_rd |=> o_handoff_enable == (o_rdata[15:12] != 4'h0);
	endproperty
	property p_ports;
		s_rd |=> o_rdata[3:0] != 4'h0;
	endproperty
	property p_cover;
		s_rd |=> o_rdata[15:12] == 4'h0 || w_cover >= o_rdata[3:0];
	endproperty
	property p_res;
		s_rd |=> o_rdata[31:17] == 15'h0 && o_rdata[6:5] == 2'h0;
	endproperty
	property p_hold;
		!i_rd |=> $stable(o_rdata);
	endproperty
	property p_valid;
		s_rd |=> o_port_reg_valid == (15'h7FFF >> (4'hF - o_rdata[3:0]));
	endproperty
	property p_pwr;
		s_rd |=> o_rdata[4] || &o_port_pwr;
	endproperty
	property p_ind;
		s_rd |=> o_rdata[16] || o_port_ind == '0;
	endproperty
	a_hand: assert property (p_hand) else $error("handoff wrong");
	a_ports: assert property (p_ports) else $error("zero ports");
	a_cover: assert property (p_cover) else $error("ports uncovered");
	a_res: assert property (p_res) else $error("reserved set");
	a_hold: assert property (p_hold) else $error("rdata moved");
	a_valid: assert property (p_valid) else $error("port regs");
	a_pwr: assert property (p_pwr) else $error("power field");
	a_ind: assert property (p_ind) else $error("indicator");
endmodule
bind hsp_struct_params hsp_struct_params_assertions #(
	.N_PORTS(N_PORTS)
) u_chk (.*);
`default_nettype wire

// ===== verif/hsp_struct_params_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_struct_params_bench;
	localparam [3:0] NP = 4'h4, CC = 4'h2, PCC = 4'h2;
	reg         i_clk = 1'b0, i_rstn = 1'b0, i_strap = 1'b1;
	reg         i_rd = 1'b0, i_wr = 1'b0;
	reg  [7:0]  i_addr = 8'h00;
	reg  [3:0]  i_port_sel = 4'h0;
	reg  [31:0] i_wdata = 32'h0, exp, d;
	wire [31:0] o_rdata;
	wire        o_he;
	wire [3:0]  o_comp, o_pwr;
	wire [14:0] o_val;
	wire [7:0]  o_ind;
	integer     n_fail = 0, checked = 0, cyc = 0, p;
	hsp_struct_params #(.ROUTE(1'b0)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_amber_led_strap_three(i_strap), .i_addr(i_addr), .i_rd(i_rd),
		.i_wr(i_wr), .i_wdata(i_wdata), .i_port_sel(i_port_sel),
		.o_rdata(o_rdata), .o_handoff_enable(o_he), .o_port_companion(o_comp),
		.o_port_reg_valid(o_val), .o_port_ind(o_ind), .o_port_pwr(o_pwr));
	wire [31:0] o_rdata2, o_rdata3;
	wire [3:0]  o_comp2, o_comp3, o_pwr2;
	wire        o_he3;
	hsp_struct_params #(.PWR_CAP(1'b0), .ROUTE_ARRAY(60'h0101)) uut_route (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_amber_led_strap_three(i_strap),
		.i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
		.i_port_sel(i_port_sel), .o_rdata(o_rdata2),
		.o_handoff_enable(), .o_port_companion(o_comp2),
		.o_port_reg_valid(), .o_port_ind(), .o_port_pwr(o_pwr2));
	hsp_struct_params #(.N_CC(4'h0)) uut_nocc (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_amber_led_strap_three(i_strap),
		.i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
		.i_port_sel(i_port_sel), .o_rdata(o_rdata3),
		.o_handoff_enable(o_he3), .o_port_companion(o_comp3),
		.o_port_reg_valid(), .o_port_ind(), .o_port_pwr());
	initial begin
		forever #25 i_clk = ~i_clk;
	end
	task automatic chk(input string nm, input [31:0] seen, input [31:0] ex);
		checked = checked + 1;
		if (seen !== ex) begin
			n_fail = n_fail + 1;
			$display("MISMATCH %0s exp %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic acc(input rw, input [7:0] a, input [31:0] d);
		@(negedge i_clk);
		i_rd = !rw;
		i_wr = rw;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
		i_rd = 1'b0;
		i_wr = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic rst(input s);
		i_rstn = 1'b0;
		i_strap = s;
		repeat (5) @(negedge i_clk);
		i_rstn = 1'b1;
	endtask
	task automatic finish_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			finish_test;
		end
	end
	initial begin
		rst(1'b1);
		exp = {15'h0, 1'b1, CC, PCC, 1'b0, 2'b00, 1'b1, NP};
		acc(1'b0, 8'h04, 32'h0);
		chk("params", o_rdata, exp);
		chk("routed", o_rdata2, exp ^ 32'h00000090);
		chk("nocomp", o_rdata3, exp & 32'hFFFF0FFF | 32'h80);
		chk("nohandoff", o_he3, 32'h0);
		acc(1'b1, 8'h04, 32'hFFFFFFFF);
		acc(1'b0, 8'h04, 32'h0);
		chk("readonly", o_rdata, exp);
		acc(1'b0, 8'h08, 32'h0);
		chk("unmapped", o_rdata, 32'h0);
		chk("handoff", o_he, 32'h1);
		chk("portregs", o_val, 32'h000F);
		for (p = 0; p < 4; p = p + 1) begin
			i_port_sel = 4'(p);
			d = p[0] ? 32'h00009000 : 32'h00004000;
			acc(1'b1, 8'(8'h44 + 4 * p), d);
			chk("companion", o_comp, 32'(p / PCC));
			chk("route", o_comp2, 32'(!p[0]));
			chk("nocompanion", o_comp3, 32'h0);
			chk("indicator", o_ind[2*p+:2], 32'(d[15:14]));
			chk("power", o_pwr[p], 32'(d[12]));
			chk("forced", o_pwr2[p], 32'h1);
			acc(1'b0, 8'(8'h44 + 4 * p), 32'h0);
			chk("portread", o_rdata, d);
		end
		i_port_sel = 4'h5;
		acc(1'b0, 8'h54, 32'h0);
		chk("noport4", o_rdata, 32'h0);
		chk("beyond", o_comp, 32'h0);
		rst(1'b0);
		acc(1'b0, 8'h04, 32'h0);
		chk("nostrap", o_rdata, exp & 32'hFFFEFFFF);
		acc(1'b1, 8'h44, 32'h9000);
		chk("noind", o_ind, 32'h0);
		finish_test;
	end
endmodule
`default_nettype wire
